// ==== rtl/edc_consts.svh ====
// constants for the flow-through edc slice: config codes, register map
// assumes inclusion by bare name from design files
`ifndef EDC_CONSTS_SVH
`define EDC_CONSTS_SVH

`define CFG_SINGLE32 2'h0
`define CFG_GEN64 2'h1
`define CFG_LOWER 2'h2
`define CFG_UPPER 2'h3

`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_SYSIN 12'h008
`define REG_PIPE 12'h00C
`define REG_MEMIN 12'h010
`define REG_CBIN 12'h014
`define REG_MERGED 12'h018
`define REG_CBOUT 12'h01C

`define CTRL_RESET 32'h0000_00F1
`define CTRL_CFG_LSB 0
`define CTRL_SOE_BIT 2
`define CTRL_BE_LSB 4
`define CTRL_GO_BIT 8
`define CTRL_RD_BIT 9

`endif

// ==== rtl/edc_pkg.sv ====
// types shared by the edc slice modules
// assumes constants come from edc_consts.svh
package edc_pkg;
    typedef logic [31:0] word_t;
    typedef logic [7:0] cb_t;
    typedef logic [1:0] cfg_t;
endpackage

// ==== rtl/checkbit_gen.sv ====
// parity-tree check-bit generator over a parameterised data width
// assumes a pure combinational use; no clock
`timescale 1ns/1ps
module checkbit_gen #(
    parameter int W = 32,
    parameter int SEED = 0
)
(
    input wire logic [W-1:0] data,
    output logic [7:0] cb
);
    // each check bit covers data bits whose hashed index selects it
    genvar g;
    generate
        for (g = 0; g < 8; g++)
        begin : g_cb
            logic [W-1:0] m;
            for (genvar b = 0; b < W; b++)
            begin : g_m
                localparam int H = ((b + SEED) * 5 + 3) % 255 + 1;
                assign m[b] = ((H >> g) & 1) == 1;
            end
            assign cb[g] = ^(data & m);
        end
    endgenerate
endmodule // checkbit_gen

// ==== rtl/byte_merge.sv ====
// byte-wise merge mux: low select takes system latch, high takes pipeline
// assumes selects come from a registered source
`timescale 1ns/1ps
module byte_merge #(
    parameter int LANES = 4
)
(
    input wire logic [LANES-1:0] sel,
    input wire logic [LANES*8-1:0] a,
    input wire logic [LANES*8-1:0] b,
    output logic [LANES*8-1:0] y
);
    genvar i;
    generate
        for (i = 0; i < LANES; i++)
        begin : g_lane
            assign y[i*8 +: 8] = sel[i] ? b[i*8 +: 8] : a[i*8 +: 8];
        end
    endgenerate
endmodule // byte_merge

// ==== rtl/edc_slice.sv ====
// flow-through edc slice with byte merge, 64-bit generate and cascade
// assumes an axi4-lite master on CLK; one write and one read outstanding
// Overview of operation
// - four lane selects with output enable gate each system byte driver
// - lane selects steer byte mux between system latch and pipeline latch
// - memory read is corrected and loaded into the pipeline latch
// - low selects take new system bytes, high ones keep pipeline bytes
// - merged word goes to memory together with its generated check bits
// - config code 01 makes the slice a 64-bit check-bit generator
// - generate mode drives 8 check bits over 64 bits onto check output
// - generate mode disables detect, correct and merge functions
// - three generators: two for system data (merged word and upper half) and one for memory data
// - lower slice forms partial syndrome from own data and stored bits
// - upper slice makes partial check bits and exchanges them
// - each slice computes final syndrome and corrects own half
// - upper slice takes lower partial syndrome on partial check-bit input bus
//
// Added by the designer: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "edc_consts.svh"
module edc_slice
(
    input wire logic CLK,
    input wire logic NRST,
    input wire logic [11:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [11:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    input wire logic [31:0] SYSTEM_DATA_BUS_I,
    output logic [31:0] SYSTEM_DATA_BUS_O,
    output logic [3:0] SYSTEM_DATA_BUS_OE,
    input wire logic [31:0] MEMORY_DATA_BUS_I,
    output logic [31:0] MEMORY_DATA_BUS_O,
    output logic MEMORY_DATA_BUS_OE,
    input wire logic [7:0] CHECKBIT_IN_BUS,
    input wire logic [7:0] PARTIAL_CHECKBIT_IN_BUS,
    output logic [7:0] CHECKBIT_OUT_BUS,
    output logic [7:0] SYNDROME_OUT_BUS
);
    edc_pkg::word_t sys_s1, sys_s2, mem_s1, mem_s2, merged;
    edc_pkg::cb_t cbi_s1, cbi_s2, pcb_s1, pcb_s2;
    edc_pkg::cb_t gen_sys, gen_mem, gen_hi, syn_part, syn_final;
    edc_pkg::word_t ctrl_q, sys_latch_q, pipe_q, corrected;
    edc_pkg::cb_t cbo_q, syo_q;
    logic [31:0] mdo_q;
    logic [3:0] oe_q;
    logic mdoe_q, single_err_q, multi_err_q;
    edc_pkg::cfg_t cfg;
    logic [3:0] be;
    logic system_output_enable, gen64;
    logic aw_ok, w_ok, wr_go;
    logic [11:0] aw_q;
    logic [31:0] w_q;
    logic go_pulse, rd_pulse;

    assign cfg = edc_pkg::cfg_t'(ctrl_q[`CTRL_CFG_LSB +: 2]);
    assign system_output_enable = ctrl_q[`CTRL_SOE_BIT];
    assign be = ctrl_q[`CTRL_BE_LSB +: 4];
    assign gen64 = (cfg == `CFG_GEN64);

    // pins are asynchronous to CLK, so each passes two flops
    always_ff @(posedge CLK)
    begin
        sys_s1 <= SYSTEM_DATA_BUS_I;
        sys_s2 <= sys_s1;
        mem_s1 <= MEMORY_DATA_BUS_I;
        mem_s2 <= mem_s1;
        cbi_s1 <= CHECKBIT_IN_BUS;
        cbi_s2 <= cbi_s1;
        pcb_s1 <= PARTIAL_CHECKBIT_IN_BUS;
        pcb_s2 <= pcb_s1;
    end

    byte_merge #(.LANES(4)) u_merge
    (
        .sel(gen64 ? 4'hF : be),
        .a(sys_latch_q),
        .b(pipe_q),
        .y(merged)
    );

    // system-side generator sees the merged word, or the upper half in gen64
    checkbit_gen #(.W(32), .SEED(0)) u_gen_sys
    (
        .data(gen64 ? sys_s2 : merged),
        .cb(gen_sys)
    );
    checkbit_gen #(.W(32), .SEED(0)) u_gen_mem
    (
        .data(mem_s2),
        .cb(gen_mem)
    );
    checkbit_gen #(.W(32), .SEED(32)) u_gen_hi
    (
        .data(sys_s2),
        .cb(gen_hi)
    );

    // partial syndrome: lower uses stored bits, upper uses its partial only
    always_comb
    begin
        unique case (cfg)
            `CFG_UPPER: syn_part = gen_mem;
            default: syn_part = gen_mem ^ cbi_s2;
        endcase
        unique case (cfg)
            `CFG_LOWER: syn_final = syn_part ^ pcb_s2;
            `CFG_UPPER: syn_final = gen_mem ^ cbi_s2 ^ pcb_s2;
            default: syn_final = syn_part;
        endcase
    end

    // single flip: the bit whose generator mask equals the syndrome
    always_comb
    begin
        corrected = mem_s2;
        for (int b = 0; b < 32; b++)
        begin
            if (syn_final == 8'(((b + (cfg == `CFG_UPPER ? 32 : 0)) * 5 + 3)
                % 255 + 1))
            begin
                corrected[b] = ~mem_s2[b];
            end
        end
    end

    // axi4-lite write path: address and data taken in either order
    assign wr_go = aw_ok && w_ok && !BVALID;
    always_ff @(posedge CLK)
    begin
        if (!NRST)
        begin
            AWREADY <= 1'b1;
            WREADY <= 1'b1;
            aw_ok <= 1'b0;
            w_ok <= 1'b0;
            aw_q <= 12'h000;
            w_q <= 32'h0000_0000;
            BVALID <= 1'b0;
            BRESP <= 2'h0;
        end
        else
        begin
            if (AWVALID && AWREADY)
            begin
                aw_q <= AWADDR;
                aw_ok <= 1'b1;
                AWREADY <= 1'b0;
            end
            if (WVALID && WREADY)
            begin
                w_q <= WDATA;
                w_ok <= 1'b1;
                WREADY <= 1'b0;
            end
            if (wr_go)
            begin
                aw_ok <= 1'b0;
                w_ok <= 1'b0;
                BVALID <= 1'b1;
                BRESP <= (aw_q == `REG_CTRL || aw_q == `REG_SYSIN) ?
                    2'h0 : 2'h2;
            end
            if (BVALID && BREADY)
            begin
                BVALID <= 1'b0;
                AWREADY <= 1'b1;
                WREADY <= 1'b1;
            end
        end
    end

    // control register; go and rd bits self-clear into pulses
    always_ff @(posedge CLK)
    begin
        if (!NRST)
        begin
            ctrl_q <= `CTRL_RESET;
            go_pulse <= 1'b0;
            rd_pulse <= 1'b0;
        end
        else
        begin
            go_pulse <= 1'b0;
            rd_pulse <= 1'b0;
            if (wr_go && aw_q == `REG_CTRL)
            begin
                ctrl_q <= w_q & 32'h0000_00F7;
                go_pulse <= w_q[`CTRL_GO_BIT];
                rd_pulse <= w_q[`CTRL_RD_BIT];
            end
        end
    end

    // system latch: only software loads it, as a whole word; write strobes are ignored
    always_ff @(posedge CLK)
    begin
        if (!NRST)
        begin
            sys_latch_q <= 32'h0000_0000;
        end
        else if (wr_go && aw_q == `REG_SYSIN)
        begin
            sys_latch_q <= w_q;
        end
    end

    // pipeline latch holds the corrected read word; frozen in gen64
    always_ff @(posedge CLK)
    begin
        if (!NRST)
        begin
            pipe_q <= 32'h0000_0000;
            single_err_q <= 1'b0;
            multi_err_q <= 1'b0;
        end
        else if (rd_pulse && !gen64)
        begin
            pipe_q <= corrected;
            single_err_q <= (corrected != mem_s2);
            multi_err_q <= (syn_final != 8'h00) && (corrected == mem_s2);
        end
    end

    // memory write of the merged word; check bits from the mux output, xor partial input in upper, gen_mem in lower
    always_ff @(posedge CLK)
    begin
        if (!NRST)
        begin
            mdo_q <= 32'h0000_0000;
            mdoe_q <= 1'b0;
        end
        else if (gen64)
        begin
            mdoe_q <= 1'b0;
        end
        else if (go_pulse)
        begin
            mdo_q <= merged;
            mdoe_q <= 1'b1;
        end
        else if (rd_pulse)
        begin
            mdoe_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!NRST)
        begin
            cbo_q <= 8'h00;
            syo_q <= 8'h00;
            oe_q <= 4'h0;
        end
        else
        begin
            // gen64 check bits span both halves of the 64-bit word
            if (gen64)
                cbo_q <= gen_mem ^ gen_hi;
            else if (cfg == `CFG_LOWER)
                cbo_q <= gen_mem;
            else
                cbo_q <= gen_sys ^ (cfg == `CFG_UPPER ? pcb_s2 : 8'h00);
            syo_q <= gen64 ? 8'h00 : (cfg == `CFG_UPPER ? gen_mem :
                (cfg == `CFG_LOWER ? syn_part : syn_final));
            oe_q <= (system_output_enable && !gen64) ? ~be : 4'h0;
        end
    end

    // axi4-lite read path
    always_ff @(posedge CLK)
    begin
        if (!NRST)
        begin
            ARREADY <= 1'b1;
            RVALID <= 1'b0;
            RDATA <= 32'h0000_0000;
            RRESP <= 2'h0;
        end
        else if (ARVALID && ARREADY)
        begin
            ARREADY <= 1'b0;
            RVALID <= 1'b1;
            RRESP <= 2'h0;
            unique case (ARADDR)
                `REG_CTRL: RDATA <= ctrl_q;
                `REG_STATUS: RDATA <= {30'h0, multi_err_q, single_err_q};
                `REG_SYSIN: RDATA <= sys_latch_q;
                `REG_PIPE: RDATA <= pipe_q;
                `REG_MEMIN: RDATA <= mem_s2;
                `REG_CBIN: RDATA <= {24'h00_0000, cbi_s2};
                `REG_MERGED: RDATA <= merged;
                `REG_CBOUT: RDATA <= {16'h0000, syo_q, cbo_q};
                default:
                begin
                    RDATA <= 32'h0000_0000;
                    RRESP <= 2'h2;
                end
            endcase
        end
        else if (RVALID && RREADY)
        begin
            RVALID <= 1'b0;
            ARREADY <= 1'b1;
        end
    end

    assign SYSTEM_DATA_BUS_O = pipe_q;
    assign SYSTEM_DATA_BUS_OE = oe_q;
    assign MEMORY_DATA_BUS_O = mdo_q;
    assign MEMORY_DATA_BUS_OE = mdoe_q;
    assign CHECKBIT_OUT_BUS = cbo_q;
    assign SYNDROME_OUT_BUS = syo_q;

    property p_oe;
        @(posedge CLK) disable iff (!NRST)
        1'b1 |=> SYSTEM_DATA_BUS_OE == (($past(system_output_enable) && !$past(gen64)) ?
            ~$past(be) : 4'h0);
    endproperty
    AST_OE_PER_LANE: assert property (p_oe)
        else $error("lane enables wrong");
    AST_GEN64_NO_OE: assert property (@(posedge CLK) disable iff (!NRST)
        gen64 && $past(gen64) |-> SYSTEM_DATA_BUS_OE == 4'h0)
        else $error("drivers on in gen64");
    AST_GEN64_CB: assert property (@(posedge CLK) disable iff (!NRST)
        gen64 |=> CHECKBIT_OUT_BUS == $past(gen_mem ^ gen_hi))
        else $error("gen64 check bits wrong");
    AST_MERGE_WRITE: assert property (@(posedge CLK) disable iff (!NRST)
        go_pulse && !gen64 |=> MEMORY_DATA_BUS_O == $past(merged)
        && MEMORY_DATA_BUS_OE)
        else $error("merged word not written");
    AST_PIPE_LOAD: assert property (@(posedge CLK) disable iff (!NRST)
        rd_pulse && !gen64 |=> pipe_q == $past(corrected))
        else $error("pipeline not loaded");
    AST_PIPE_FROZEN: assert property (@(posedge CLK) disable iff (!NRST)
        gen64 && rd_pulse |=> $stable(pipe_q))
        else $error("pipeline moved in gen64");
    AST_LOWER_SYO: assert property (@(posedge CLK) disable iff (!NRST)
        cfg == `CFG_LOWER |=> SYNDROME_OUT_BUS ==
        $past(gen_mem ^ cbi_s2))
        else $error("partial syndrome wrong");
    AST_UPPER_SYO: assert property (@(posedge CLK) disable iff (!NRST)
        cfg == `CFG_UPPER |=> SYNDROME_OUT_BUS == $past(gen_mem))
        else $error("upper partial wrong");
endmodule // edc_slice

// ==== verification/memory_model.sv ====
// far-side model: one protected memory word and its stored check bits
// assumes the slice drives the memory bus only while its enable is high
`timescale 1ns/1ps
module memory_model
(
    input wire logic clk,
    input wire logic [31:0] dev_data,
    input wire logic dev_oe,
    input wire logic [7:0] dev_cb,
    input wire logic load,
    input wire logic [31:0] load_data,
    input wire logic [31:0] flip,
    output logic [31:0] bus_data,
    output logic [7:0] bus_cb
);
    logic [31:0] word_q;
    logic [7:0] cb_q;
    // a load clears the check bits, so it only suits generate mode
    always_ff @(posedge clk)
    begin
        if (load)
        begin
            word_q <= load_data;
            cb_q <= 8'h00;
        end
        else if (dev_oe)
        begin
            word_q <= dev_data;
            cb_q <= dev_cb;
        end
    end
    // flip models a stored upset; the slice wins while it drives
    assign bus_data = dev_oe ? dev_data : word_q ^ flip;
    assign bus_cb = cb_q;
endmodule // memory_model

// ==== verification/test_flowthru_edc_merge_generate.sv ====
// self-checking bench for edc_slice with a memory-side partner model
// assumes 10 MHz CLK, axi4-lite master tasks here, memory_model beside
`timescale 1ns/1ps
`include "edc_consts.svh"
module test_flowthru_edc_merge_generate;
    logic clk, nrst, awvalid, wvalid, arvalid, load;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, sys_drv, load_data, flip, rd_v, exp_v, p_v, s_v;
    logic [7:0] pcb, cb_v;
    logic [1:0] resp_v, cfg_v;
    logic awready, wready, bvalid, arready, rvalid, mem_oe;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, sys_o, mem_o, mem_w, sys_w, oe_mask;
    logic [3:0] sys_oe;
    logic [7:0] checkbit_in_bus, checkbit_out_bus, syndrome_out_bus;
    int miscompares, compares, seed_v;
    int hv[4], lv[4], cq[4];

    edc_slice i_dut
    (
        .CLK(clk), .NRST(nrst), .AWADDR(awaddr), .AWVALID(awvalid),
        .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hF), .WVALID(wvalid),
        .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(1'b1),
        .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
        .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(1'b1),
        .SYSTEM_DATA_BUS_I(sys_w), .SYSTEM_DATA_BUS_O(sys_o),
        .SYSTEM_DATA_BUS_OE(sys_oe), .MEMORY_DATA_BUS_I(mem_w),
        .MEMORY_DATA_BUS_O(mem_o), .MEMORY_DATA_BUS_OE(mem_oe),
        .CHECKBIT_IN_BUS(checkbit_in_bus), .PARTIAL_CHECKBIT_IN_BUS(pcb),
        .CHECKBIT_OUT_BUS(checkbit_out_bus), .SYNDROME_OUT_BUS(syndrome_out_bus)
    );
    memory_model i_mem
    (
        .clk(clk), .dev_data(mem_o), .dev_oe(mem_oe), .dev_cb(checkbit_out_bus),
        .load(load), .load_data(load_data), .flip(flip),
        .bus_data(mem_w), .bus_cb(checkbit_in_bus)
    );
    // each system byte wire follows whichever side enables it
    assign oe_mask = {{8{sys_oe[3]}}, {8{sys_oe[2]}}, {8{sys_oe[1]}},
        {8{sys_oe[0]}}};
    assign sys_w = (sys_o & oe_mask) | (sys_drv & ~oe_mask);

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic report_and_stop();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic axw(input logic [11:0] a, input logic [31:0] d);
        logic aw, w;
        aw = 1'b1;
        w = 1'b1;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (aw || w)
        begin
            @(posedge clk);
            if (awready)
                aw = 1'b0;
            if (wready)
                w = 1'b0;
            awvalid <= aw;
            wvalid <= w;
        end
        do
            @(posedge clk);
        while (!bvalid);
        resp_v = bresp;
    endtask

    task automatic axr(input logic [11:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        do
            @(posedge clk);
        while (!arready);
        arvalid <= 1'b0;
        do
            @(posedge clk);
        while (!rvalid);
        rd_v = rdata;
        resp_v = rresp;
    endtask

    // selects are set before the pulse so the pulse never races them
    task automatic go_op(input logic [3:0] be, input logic [1:0] f);
        axw(`REG_CTRL, {22'h00_0000, 2'h0, be, 1'b0, 1'b1, cfg_v});
        axw(`REG_CTRL, {22'h00_0000, f, be, 1'b0, 1'b1, cfg_v});
        repeat (6) @(posedge clk);
    endtask

    function automatic logic [31:0] mrg(input logic [31:0] s,
        input logic [31:0] p, input int be);
        logic [31:0] r;
        for (int i = 0; i < 4; i++)
            r[8*i +: 8] = ((be >> i) & 1) ? p[8*i +: 8] : s[8*i +: 8];
        return r;
    endfunction

    initial
    begin
        repeat (20000) @(posedge clk);
        miscompares++;
        report_and_stop();
    end

    initial
    begin
        nrst = 1'b0;
        awvalid = 1'b0;
        wvalid = 1'b0;
        arvalid = 1'b0;
        awaddr = 12'h000;
        araddr = 12'h000;
        wdata = 32'h0000_0000;
        // preload the model word during reset so the memory pins never float
        load = 1'b1;
        load_data = 32'h0000_0000;
        flip = 32'h0000_0000;
        sys_drv = 32'h0000_0000;
        pcb = 8'h00;
        cfg_v = 2'h0;
        miscompares = 0;
        compares = 0;
        seed_v = $urandom(84);
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        load <= 1'b0;
        axr(`REG_CTRL);
        chk(rd_v, 32'h0000_00F1);
        axr(12'h0F0);
        chk(rd_v, 32'h0000_0000);
        chk({30'h0, resp_v}, 32'h0000_0002);
        axw(`REG_PIPE, 32'h0000_0000);
        chk({30'h0, resp_v}, 32'h0000_0002);
        $display("test registers done");
        for (int m = 0; m < 16; m++)
        begin
            p_v = $urandom();
            s_v = $urandom();
            axw(`REG_SYSIN, p_v);
            go_op(4'h0, 2'h1);
            go_op(4'h0, 2'h2);
            axr(`REG_PIPE);
            chk(rd_v, p_v);
            axw(`REG_SYSIN, s_v);
            go_op(m[3:0], 2'h1);
            exp_v = mrg(s_v, p_v, m);
            chk({28'h0, sys_oe}, {28'h0, ~m[3:0]});
            axr(`REG_MERGED);
            chk(rd_v, exp_v);
            chk(mem_o, exp_v);
            go_op(m[3:0], 2'h2);
            axr(`REG_PIPE);
            chk(rd_v, exp_v);
            chk(sys_o, exp_v);
        end
        $display("test merge done");
        cb_v = checkbit_out_bus;
        flip <= 32'h0000_0001 << ($urandom() % 32);
        repeat (4) @(posedge clk);
        go_op(4'hF, 2'h2);
        axr(`REG_PIPE);
        chk(rd_v, exp_v);
        axr(`REG_STATUS);
        chk(rd_v & 32'h0000_0003, 32'h0000_0001);
        chk({24'h0, checkbit_out_bus}, {24'h0, cb_v});
        flip <= 32'h0000_0000;
        $display("test correction done");
        cfg_v = 2'h2;
        go_op(4'hF, 2'h0);
        chk({24'h0, syndrome_out_bus}, 32'h0000_0000);
        cfg_v = 2'h3;
        go_op(4'hF, 2'h0);
        chk({24'h0, syndrome_out_bus}, {24'h0, checkbit_in_bus});
        go_op(4'hF, 2'h2);
        axr(`REG_PIPE);
        chk(rd_v, exp_v);
        $display("test cascade done");
        cfg_v = 2'h0;
        go_op(4'h0, 2'h1);
        cfg_v = 2'h1;
        go_op(4'h0, 2'h1);
        chk({31'h0, mem_oe}, 32'h0000_0000);
        chk({28'h0, sys_oe}, 32'h0000_0000);
        go_op(4'h0, 2'h2);
        axr(`REG_PIPE);
        chk(rd_v, exp_v);
        for (int k = 0; k < 4; k++)
        begin
            hv[k] = (k == 2) ? hv[0] ^ hv[1] : (k == 3 ? 0 : $urandom());
            lv[k] = (k == 2) ? lv[0] ^ lv[1] : (k == 3 ? 0 : $urandom());
            sys_drv <= hv[k];
            load_data <= lv[k];
            load <= 1'b1;
            @(posedge clk);
            load <= 1'b0;
            repeat (6) @(posedge clk);
            cq[k] = checkbit_out_bus;
        end
        chk(cq[0] ^ cq[1], cq[2] ^ cq[3]);
        $display("test generate done");
        report_and_stop();
    end
endmodule // test_flowthru_edc_merge_generate
